// >>> pkg/csc_defs.svh
`ifndef CSC_DEFS_SVH
`define CSC_DEFS_SVH

// Register indices; byte address is four times the index
`define CSC_IDX_CTRL0    8'ha0
`define CSC_IDX_CTRL1    8'ha1
`define CSC_IDX_CTRL2    8'ha2
`define CSC_IDX_CTRL3    8'ha3
`define CSC_IDX_CNT_LO   8'ha4
`define CSC_IDX_CNT_HI   8'ha5
`define CSC_IDX_FLAGS    8'ha6
`define CSC_IDX_LIMIT    8'ha7
`define CSC_IDX_SLEW     8'ha8
`define CSC_IDX_LEVEL    8'hfd

// Reset value shared by every register
`define CSC_RST_BYTE     8'h00

// Writable bits; reserved bits hold zero
`define CSC_WMASK_CTRL0  8'hc7
`define CSC_WMASK_CTRL1  8'hff
`define CSC_WMASK_CTRL2  8'hf7
`define CSC_WMASK_CTRL3  8'hff
`define CSC_WMASK_LIMIT  8'h3f
`define CSC_WMASK_SLEW   8'hff
`define CSC_WMASK_LEVEL  8'hff
`define CSC_WMASK_FMASK  8'h03

// Field positions
`define CSC_CTRL0_EN     0
`define CSC_CTRL1_DIV_LO 4
`define CSC_CTRL1_DIV_HI 5
`define CSC_CTRL2_RNG_LO 6
`define CSC_CTRL2_RNG_HI 7
`define CSC_CTRL2_SRC_EN 4
`define CSC_SLEW_EN      0
`define CSC_SLEW_DUR_LO  1
`define CSC_SLEW_DUR_HI  7
`define CSC_FLAG_DONE    4
`define CSC_FLAG_OVF     5
`define CSC_MASK_DONE    0
`define CSC_MASK_OVF     1

// Divider counter width in bits
`define CSC_DIV_BITS     3

`endif

// >>> pkg/csc_pkg.sv
package csc_pkg;

  typedef enum logic [1:0] {
    CSC_T_IDLE,
    CSC_T_COUNT,
    CSC_T_DONE
  } csc_timer_state_type;

  typedef logic [7:0] csc_byte_type;

endpackage

// >>> pkg/csc_timer_if.sv
`timescale 1ns/1ps
`default_nettype none

interface csc_timer_if #(
  parameter int CW = 6
);
  logic          tick;
  logic          enable;
  logic [CW-1:0] limit;
  logic          active;
  logic          capture;
  logic          terminal;

  modport ctl (
    output tick,
    output enable,
    output limit,
    input  active,
    input  capture,
    input  terminal
  );

  modport tmr (
    input  tick,
    input  enable,
    input  limit,
    output active,
    output capture,
    output terminal
  );
endinterface

`default_nettype wire

// >>> rtl/csc_timer.sv
`timescale 1ns/1ps
`default_nettype none

module csc_timer
  import csc_pkg::*;
#(
  parameter int CW = 6
) (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic srst,
  // Timer link
  csc_timer_if.tmr  tif
);

  logic                sync_a;
  logic                sync_b;
  logic [CW-1:0]       count;
  csc_timer_state_type state;

  // two stage enable
  // Disable clears at once so a restart never sees a stale start
  always_ff @(posedge ref_clk) begin
    if (srst || !tif.enable) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
    end else if (tif.tick) begin
      sync_a <= 1'b1;
      sync_b <= sync_a;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst || !sync_b) begin
      state <= CSC_T_IDLE;
      count <= '0;
    end else if (tif.tick) begin
      case (state)
        CSC_T_IDLE: begin
          count <= tif.limit;
          state <= CSC_T_COUNT;
        end
        CSC_T_COUNT: begin
          if (count == '0) begin
            state <= CSC_T_DONE;
          end else begin
            count <= count - 1'b1;
          end
        end
        CSC_T_DONE: begin
          state <= CSC_T_DONE;
        end
        default: begin
          state <= CSC_T_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst || !sync_b) begin
      tif.terminal <= 1'b0;
    end else if (tif.tick) begin
      tif.terminal <= (state == CSC_T_COUNT) && (count == '0);
    end
  end

  assign tif.active  = (state == CSC_T_COUNT);
  assign tif.capture = tif.tick && (state == CSC_T_COUNT)
                       && (count == '0);

endmodule

`default_nettype wire

// >>> rtl/csc_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "csc_defs.svh"

// Overview of operation
// - Interval is a programmed count of oscillator cycles, 6-bit counter.
// - 16-bit counter runs on divided main clock during the interval.
// - Dual slew: fast rate for fixed time each edge, then slow.
// - Current source level comes from an 8-bit register.
// - Two-bit range field in control 2 prescales the current.
// - At terminal count the 16-bit count is captured as result.
// - Enable passes two flip-flop stages before the timer starts.
// - Timer loads, counts down once to zero, stops until re-enabled.
// - Terminal count pulse is high for exactly one oscillator cycle.
module csc_top
  import csc_pkg::*;
#(
  parameter int AW = 10,
  parameter int CW = 6,
  parameter int RW = 16
) (
  // Clock and reset
  input  wire logic          ref_clk,
  input  wire logic          srst,
  // Wishbone slave
  input  wire logic [AW-1:0] wb_adr_i,
  input  wire logic [31:0]   wb_dat_i,
  input  wire logic          wb_we_i,
  input  wire logic [3:0]    wb_sel_i,
  input  wire logic          wb_cyc_i,
  input  wire logic          wb_stb_i,
  output logic      [31:0]   wb_dat_o,
  output logic               wb_ack_o,
  // Relaxation oscillator
  input  wire logic          relaxation_oscillator_in,
  output logic               quick_edge_drive,
  // Sense current source
  output logic      [7:0]    sense_current_source_level,
  output logic      [1:0]    current_prescale_select,
  output logic               sense_current_source_enable,
  // Status
  output logic               measuring,
  output logic               irq
);

  // Register bank
  csc_byte_type sense_control_0;
  csc_byte_type sense_control_1;
  csc_byte_type sense_control_2;
  csc_byte_type sense_control_3;
  csc_byte_type oscillator_cycle_limit;
  csc_byte_type edge_rate_control;
  csc_byte_type current_level_value;
  csc_byte_type event_mask;
  logic [1:0]   event_status;
  logic [RW-1:0] result_count;

  // Bus decode
  logic         bus_req;
  logic         bus_wr;
  logic [7:0]   bus_idx;
  csc_byte_type bus_wdat;
  csc_byte_type rd_byte;

  // Oscillator edges
  logic         osc_q;
  logic         osc_rise;
  logic         osc_edge;

  // Count clock and counter
  logic [`CSC_DIV_BITS-1:0] div_cnt;
  logic         count_tick;
  logic [RW-1:0] sense_count;
  logic         count_ovf;

  // Slew timing
  logic [6:0]   quick_left;

  // Events
  logic         ev_done;
  logic         ev_ovf;

  // Timer link
  csc_timer_if #(.CW(CW)) tif ();

  // Register index match
  function automatic logic idx_hit(
    input logic [7:0] idx,
    input logic [7:0] target
  );
    idx_hit = (idx == target);
  endfunction

  // Masked byte write
  function automatic csc_byte_type wr_byte(
    input csc_byte_type data,
    input csc_byte_type mask
  );
    wr_byte = data & mask;
  endfunction

  // Divider select to tick test
  function automatic logic div_done(
    input logic [`CSC_DIV_BITS-1:0] cnt,
    input logic [1:0]               sel
  );
    logic [`CSC_DIV_BITS-1:0] top;
    top = '0;
    case (sel)
      2'h0: top = 3'h0;
      2'h1: top = 3'h1;
      2'h2: top = 3'h3;
      default: top = 3'h7;
    endcase
    div_done = (cnt >= top);
  endfunction

  assign bus_req  = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign bus_wr   = bus_req && wb_we_i && wb_sel_i[0];
  assign bus_idx  = wb_adr_i[9:2];
  assign bus_wdat = wb_dat_i[7:0];

  // Answer one cycle after the request, mapped or not
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_req;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      sense_control_0 <= `CSC_RST_BYTE;
      sense_control_1 <= `CSC_RST_BYTE;
      sense_control_2 <= `CSC_RST_BYTE;
      sense_control_3 <= `CSC_RST_BYTE;
    end else if (bus_wr) begin
      if (idx_hit(bus_idx, `CSC_IDX_CTRL0)) begin
        sense_control_0 <= wr_byte(bus_wdat, `CSC_WMASK_CTRL0);
      end
      if (idx_hit(bus_idx, `CSC_IDX_CTRL1)) begin
        sense_control_1 <= wr_byte(bus_wdat, `CSC_WMASK_CTRL1);
      end
      if (idx_hit(bus_idx, `CSC_IDX_CTRL2)) begin
        sense_control_2 <= wr_byte(bus_wdat, `CSC_WMASK_CTRL2);
      end
      if (idx_hit(bus_idx, `CSC_IDX_CTRL3)) begin
        sense_control_3 <= wr_byte(bus_wdat, `CSC_WMASK_CTRL3);
      end
    end
  end

  // Timing, level and event mask registers
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      oscillator_cycle_limit <= `CSC_RST_BYTE;
      edge_rate_control      <= `CSC_RST_BYTE;
      current_level_value    <= `CSC_RST_BYTE;
      event_mask             <= `CSC_RST_BYTE;
    end else if (bus_wr) begin
      if (idx_hit(bus_idx, `CSC_IDX_LIMIT)) begin
        oscillator_cycle_limit <= wr_byte(bus_wdat,
                                          `CSC_WMASK_LIMIT);
      end
      if (idx_hit(bus_idx, `CSC_IDX_SLEW)) begin
        edge_rate_control <= wr_byte(bus_wdat, `CSC_WMASK_SLEW);
      end
      if (idx_hit(bus_idx, `CSC_IDX_LEVEL)) begin
        current_level_value <= wr_byte(bus_wdat,
                                       `CSC_WMASK_LEVEL);
      end
      if (idx_hit(bus_idx, `CSC_IDX_FLAGS)) begin
        event_mask <= wr_byte(bus_wdat, `CSC_WMASK_FMASK);
      end
    end
  end

  // Sticky events; a set in the clearing cycle wins
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      event_status <= 2'h0;
    end else begin
      if (bus_wr && idx_hit(bus_idx, `CSC_IDX_FLAGS)) begin
        event_status <= (event_status
          & ~bus_wdat[`CSC_FLAG_OVF:`CSC_FLAG_DONE])
          | {ev_ovf, ev_done};
      end else begin
        event_status <= event_status | {ev_ovf, ev_done};
      end
    end
  end

  always_comb begin
    rd_byte = 8'h00;
    case (bus_idx)
      `CSC_IDX_CTRL0:  rd_byte = sense_control_0;
      `CSC_IDX_CTRL1:  rd_byte = sense_control_1;
      `CSC_IDX_CTRL2:  rd_byte = sense_control_2;
      `CSC_IDX_CTRL3:  rd_byte = sense_control_3;
      `CSC_IDX_CNT_LO: rd_byte = result_count[7:0];
      `CSC_IDX_CNT_HI: rd_byte = result_count[15:8];
      `CSC_IDX_FLAGS:  rd_byte = {2'h0, event_status,
                                  2'h0, event_mask[1:0]};
      `CSC_IDX_LIMIT:  rd_byte = oscillator_cycle_limit;
      `CSC_IDX_SLEW:   rd_byte = edge_rate_control;
      `CSC_IDX_LEVEL:  rd_byte = current_level_value;
      default:         rd_byte = 8'h00;
    endcase
  end

  // Read data held with the acknowledge
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (bus_req && !wb_we_i) begin
      wb_dat_o <= {24'h00_0000, rd_byte};
    end
  end

  // Inputs are synchronous; one flop gives the edge
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      osc_q <= 1'b0;
    end else begin
      osc_q <= relaxation_oscillator_in;
    end
  end

  assign osc_rise = relaxation_oscillator_in && !osc_q;
  assign osc_edge = relaxation_oscillator_in ^ osc_q;

  assign tif.tick   = osc_rise;
  assign tif.enable = sense_control_0[`CSC_CTRL0_EN];
  assign tif.limit  = oscillator_cycle_limit[CW-1:0];

  csc_timer #(
    .CW (CW)
  ) i_csc_timer (
    .ref_clk (ref_clk),
    .srst    (srst),
    .tif     (tif)
  );

  // Count clock from the main clock
  always_ff @(posedge ref_clk) begin
    if (srst || !tif.active) begin
      div_cnt <= '0;
    end else if (count_tick) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= div_cnt + 1'b1;
    end
  end

  assign count_tick = tif.active && div_done(div_cnt,
    sense_control_1[`CSC_CTRL1_DIV_HI:`CSC_CTRL1_DIV_LO]);

  // count during interval
  // Cleared while disabled so every run starts from zero
  always_ff @(posedge ref_clk) begin
    if (srst || !sense_control_0[`CSC_CTRL0_EN]) begin
      sense_count <= '0;
    end else if (count_tick) begin
      sense_count <= sense_count + 1'b1;
    end
  end

  assign count_ovf = count_tick && (sense_count == '1);

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      result_count <= '0;
    end else if (tif.capture) begin
      result_count <= sense_count;
    end
  end

  assign ev_done = tif.capture;
  assign ev_ovf  = count_ovf;

  always_ff @(posedge ref_clk) begin
    if (srst || !edge_rate_control[`CSC_SLEW_EN]) begin
      quick_left <= 7'h00;
    end else if (osc_edge) begin
      quick_left <= edge_rate_control[`CSC_SLEW_DUR_HI:
                                      `CSC_SLEW_DUR_LO];
    end else if (quick_left != 7'h00) begin
      quick_left <= quick_left - 7'h01;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      quick_edge_drive <= 1'b0;
    end else begin
      quick_edge_drive <= edge_rate_control[`CSC_SLEW_EN]
        && (osc_edge || (quick_left > 7'h01));
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      sense_current_source_level  <= 8'h00;
      current_prescale_select     <= 2'h0;
      sense_current_source_enable <= 1'b0;
    end else begin
      sense_current_source_level  <= current_level_value;
      current_prescale_select     <= sense_control_2[
        `CSC_CTRL2_RNG_HI:`CSC_CTRL2_RNG_LO];
      sense_current_source_enable <= sense_control_2[
        `CSC_CTRL2_SRC_EN];
    end
  end

  // Status and interrupt outputs
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      measuring <= 1'b0;
      irq       <= 1'b0;
    end else begin
      measuring <= tif.active;
      irq       <= |(event_status & event_mask[1:0]);
    end
  end

endmodule

`default_nettype wire

// >>> dv/csc_top_props.sv
`timescale 1ns/1ps
`default_nettype none

module csc_top_props #(
  parameter int AW = 10
) (
  // Clock and reset
  input wire logic          ref_clk,
  input wire logic          srst,
  // Wishbone slave
  input wire logic [AW-1:0] wb_adr_i,
  input wire logic [31:0]   wb_dat_i,
  input wire logic          wb_we_i,
  input wire logic [3:0]    wb_sel_i,
  input wire logic          wb_cyc_i,
  input wire logic          wb_stb_i,
  input wire logic [31:0]   wb_dat_o,
  input wire logic          wb_ack_o,
  // Oscillator and current source
  input wire logic          relaxation_oscillator_in,
  input wire logic          quick_edge_drive,
  input wire logic [7:0]    sense_current_source_level,
  input wire logic [1:0]    current_prescale_select,
  input wire logic          sense_current_source_enable,
  // Status
  input wire logic          measuring,
  input wire logic          irq
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  logic [7:0] ridx;
  logic       unmapped;
  logic [7:0] qcnt;
  logic       osc_in;
  assign ridx     = wb_adr_i[9:2];
  assign unmapped = (ridx < 8'ha0) || (ridx > 8'ha8 && ridx != 8'hfd);
  assign osc_in   = relaxation_oscillator_in;

  // Saturates so a stuck drive cannot wrap back into range
  // Each new edge rightly reopens the fast phase
  always_ff @(posedge ref_clk) begin
    if (srst || !quick_edge_drive || $changed(osc_in)) begin
      qcnt <= 8'h00;
    end else if (qcnt != 8'hff) begin
      qcnt <= qcnt + 8'h01;
    end
  end

  chk_ack_timing: assert property (
    wb_ack_o == $past(wb_cyc_i & wb_stb_i & !wb_ack_o))
    else $error("ack not one cycle after request");
  chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_read_upper: assert property (
    wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
    else $error("upper read bits not zero");
  chk_unmapped_zero: assert property (
    wb_ack_o && !wb_we_i && unmapped |-> wb_dat_o[7:0] == 8'h00)
    else $error("unmapped read not zero");
  chk_level_write: assert property (
    !$stable(sense_current_source_level) |->
      $past(wb_we_i & wb_ack_o) || $past(wb_we_i & wb_ack_o, 2))
    else $error("level changed without a write");
  chk_range_write: assert property (
    !$stable(current_prescale_select) |->
      $past(wb_we_i & wb_ack_o) || $past(wb_we_i & wb_ack_o, 2))
    else $error("prescale changed without a write");
  chk_meas_tick: assert property (
    $rose(measuring) |-> $past(relaxation_oscillator_in) ||
      $past(relaxation_oscillator_in, 2) ||
      $past(relaxation_oscillator_in, 3))
    else $error("measuring began without a tick");
  chk_quick_edge: assert property (
    $rose(quick_edge_drive) |->
      $past(osc_in) != $past(osc_in, 2) ||
      $past(osc_in, 2) != $past(osc_in, 3) ||
      $past(osc_in, 3) != $past(osc_in, 4))
    else $error("quick drive without an edge");
  chk_quick_bound: assert property (qcnt <= 8'h7f)
    else $error("quick drive too long");

  cover property (wb_ack_o && wb_we_i);
  cover property ($rose(measuring));
  cover property ($rose(irq));
  cover property ($fell(quick_edge_drive));
endmodule

bind csc_top csc_top_props #(.AW(AW)) i_csc_top_props (
  .ref_clk(ref_clk), .srst(srst), .wb_adr_i(wb_adr_i),
  .wb_dat_i(wb_dat_i), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .relaxation_oscillator_in(relaxation_oscillator_in),
  .quick_edge_drive(quick_edge_drive),
  .sense_current_source_level(sense_current_source_level),
  .current_prescale_select(current_prescale_select),
  .sense_current_source_enable(sense_current_source_enable),
  .measuring(measuring), .irq(irq)
);

`default_nettype wire

// >>> dv/csc_osc_model.sv
`timescale 1ns/1ps
`default_nettype none

module csc_osc_model (
  // Clock and control
  input  wire logic       ref_clk,
  input  wire logic       run,
  input  wire logic [7:0] half_period,
  // Oscillator level
  output logic            osc_out
);
  logic [7:0] phase;
  logic       osc_q = 1'b0;
  assign osc_out = osc_q;

  // Held low while stopped, so no stray ticks reach the timer
  always_ff @(posedge ref_clk) begin
    if (!run) begin
      phase <= 8'h00;
      osc_q <= 1'b0;
    end else if (phase >= half_period - 8'h01) begin
      phase <= 8'h00;
      osc_q <= !osc_q;
    end else begin
      phase <= phase + 8'h01;
    end
  end
endmodule

`default_nettype wire

// >>> dv/tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin mismatches++; \
  $display("[FAIL] t=%0t got=%0h exp=%0h", $time, (a), (e)); end end

module tb;
  logic        ref_clk = 1'b0;
  logic        srst    = 1'b1;
  logic [9:0]  adr     = 10'h000;
  logic [31:0] dat     = 32'h00000000;
  logic        we      = 1'b0;
  logic        cyc     = 1'b0;
  logic        stb     = 1'b0;
  logic [3:0]  sel     = 4'h1;
  logic        run     = 1'b0;
  logic [7:0]  hp      = 8'h04;
  wire  [31:0] rdat;
  wire         ack, osc, qe, src_en, measuring, irq;
  wire  [7:0]  level;
  wire  [1:0]  psel;
  int          mismatches = 0;
  int          compares   = 0;
  logic [7:0]  t_idx [11] = '{8'ha0, 8'ha1, 8'ha2, 8'ha3, 8'ha4, 8'ha5,
                              8'ha6, 8'ha7, 8'ha8, 8'hfd, 8'ha9};
  logic [7:0]  t_wr  [11] = '{8'hc6, 8'hff, 8'hf7, 8'hff, 8'hff, 8'hff,
                              8'h00, 8'h3f, 8'hff, 8'hff, 8'hff};
  logic [7:0]  t_rd  [11] = '{8'hc6, 8'hff, 8'hf7, 8'hff, 8'h00, 8'h00,
                              8'h00, 8'h3f, 8'hff, 8'hff, 8'h00};

  initial begin
    forever #2 ref_clk = ~ref_clk;
  end

  csc_top i_csc_top (
    .ref_clk(ref_clk), .srst(srst), .wb_adr_i(adr), .wb_dat_i(dat),
    .wb_we_i(we), .wb_sel_i(sel), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_dat_o(rdat), .wb_ack_o(ack), .relaxation_oscillator_in(osc),
    .quick_edge_drive(qe), .sense_current_source_level(level),
    .current_prescale_select(psel), .sense_current_source_enable(src_en),
    .measuring(measuring), .irq(irq));

  csc_osc_model i_csc_osc_model (
    .ref_clk(ref_clk), .run(run), .half_period(hp), .osc_out(osc));

  task automatic end_of_test();
    $display("mismatches=%0d compares=%0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic bus(input logic w, input logic [7:0] idx,
                     input logic [7:0] d, output logic [7:0] q);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= {idx, 2'b00};
    dat <= {24'h000000, d};
    do begin
      @(posedge ref_clk);
      n++;
    end while (ack !== 1'b1 && n < 64);
    if (ack !== 1'b1) begin
      mismatches++;
      end_of_test();
    end
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, idx, d, q);
  endtask

  task automatic rdc(input logic [7:0] idx, input logic [7:0] e);
    logic [7:0] q;
    bus(1'b0, idx, 8'h00, q);
    `CHK(q, e)
  endtask

  task automatic t_regs();
    `CHK({irq, measuring, qe, level}, 11'h000)
    // Reset values, then masked write and read back
    for (int i = 0; i < 11; i++) rdc(t_idx[i], 8'h00);
    // Only writable bits carry ones, except at the read-only and unmapped indices
    for (int i = 0; i < 11; i++) wr(t_idx[i], t_wr[i]);
    for (int i = 0; i < 11; i++) rdc(t_idx[i], t_rd[i]);
    `CHK({level, psel, src_en}, 11'h7ff)
    sel <= 4'h0;
    wr(8'hfd, 8'h5a);
    sel <= 4'h1;
    rdc(8'hfd, 8'hff);
    wr(8'hfd, 8'h5a);
    wr(8'ha2, 8'h40);
    repeat (2) @(posedge ref_clk);
    `CHK({level, psel, src_en}, 11'h2d2)
    wr(8'ha0, 8'h00);
    wr(8'ha8, 8'h00);
  endtask

  task automatic t_meas(input int lim, input int dv);
    logic [7:0] q, lo, hi;
    int n, c, e;
    wr(8'ha0, 8'h00);
    wr(8'ha6, 8'h30);
    wr(8'ha7, 8'(lim));
    wr(8'ha1, 8'(dv << 4));
    hp  <= 8'h04;
    run <= 1'b1;
    wr(8'ha0, 8'h01);
    n = 0;
    do begin
      bus(1'b0, 8'ha6, 8'h00, q);
      n++;
    end while (q[4] !== 1'b1 && n < 400);
    if (q[4] !== 1'b1) begin
      mismatches++;
      end_of_test();
    end
    `CHK(q, 8'h10)
    `CHK(irq, 1'b0)
    bus(1'b0, 8'ha4, 8'h00, lo);
    bus(1'b0, 8'ha5, 8'h00, hi);
    // Load to capture spans limit plus one oscillator periods
    c = int'({hi, lo});
    e = ((lim + 1) * 8) >> dv;
    `CHK(c >= e - 3 && c <= e + 3, 1'b1)
    repeat (64) @(posedge ref_clk);
    `CHK(measuring, 1'b0)
    rdc(8'ha4, lo);
    wr(8'ha6, 8'h01);
    repeat (2) @(posedge ref_clk);
    `CHK(irq, 1'b1)
    wr(8'ha6, 8'h11);
    repeat (2) @(posedge ref_clk);
    `CHK(irq, 1'b0)
    rdc(8'ha6, 8'h01);
    run <= 1'b0;
    wr(8'ha6, 8'h00);
  endtask

  task automatic t_slew(input logic [7:0] v, input int dur);
    int n, c;
    wr(8'ha8, v);
    hp  <= 8'd80;
    run <= 1'b1;
    n = 0;
    c = 0;
    while (osc !== 1'b1 && n < 200) begin
      @(posedge ref_clk);
      n++;
    end
    if (osc !== 1'b1) begin
      mismatches++;
      end_of_test();
    end
    // Window holds one rising and one falling edge
    repeat (160) begin
      @(posedge ref_clk);
      if (qe === 1'b1) c++;
    end
    `CHK(c, 2 * dur)
    run <= 1'b0;
    wr(8'ha8, 8'h00);
  endtask

  initial begin
    repeat (10) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
    t_regs();
    t_meas(3, 0);
    t_meas(63, 1);
    t_meas(0, 3);
    t_slew(8'h0b, 5);
    t_slew(8'h7f, 63);
    t_slew(8'h0a, 0);
    end_of_test();
  end
endmodule

`default_nettype wire
